// ==== hw/clk_sel_pkg.sv ====
// Constants, tables and register map of the dual clock select block.
// Assumes a 200 MHz system clock; pins reach the block already synchronous.
//
// What this block does
// - The pixel clock frequency comes from the four pixel select pins as one four-bit word.
// - The memory clock frequency comes from the three memory select pins as one word, in the table row picked by the control register variant field.
// - The memory word is binary with bit 2 on top and picks one of eight table entries.
// - A select change is accepted at any time and retunes the affected generator at once.
// - While settling, the output runs from the reference, switching glitch-free both ways.
// - A low output disable floats the outputs; left undriven it reads as enabled.
// - Undriven pixel bits 0 to 2 and memory bits read high, pixel bit 3 reads low.
// - A third output carries a buffered copy of the reference, whatever the selections.
// - A new selection becomes valid after SETTLE_REF_CYCLES reference cycles of settling, 5 ms by default.
// - A mux switch holds a high output until the new source reads low, up to one half of the new period.
// - Output disable acts on the memory clock, the pixel clock and the buffered reference.
`default_nettype none

package clk_sel_pkg;

  // ==========================================================
  // Timing
  localparam int      CLK_KHZ        = 200000;
  localparam longint  REF_HZ         = 64'd14318180;
  localparam longint  SETTLE_US_TYP  = 64'd5000;
  localparam int      SETTLE_REF_CYCLES_DEF = int'(SETTLE_US_TYP * REF_HZ / 64'd1000000);
  localparam int      CNT_W          = 20;
  localparam int      HALF_W         = 16;

  // ==========================================================
  // Pad pull defaults
  localparam logic [3:0] PIXEL_SEL_PULL  = 4'h7;
  localparam logic [2:0] MEMORY_SEL_PULL = 3'h7;
  localparam logic       OUT_DIS_PULL    = 1'h1;

  // ==========================================================
  // Memory frequency tables, kHz, one row per table variant
  localparam int MEM_VARIANTS = 3;
  localparam int MEM_KHZ [MEM_VARIANTS][8] = '{
    '{48000, 39800, 66000, 50000, 56644, 32000, 44000, 39800},
    '{48000, 39800, 66000, 50000, 56644, 32000, 44000, 39800},
    '{40000, 41000, 41500, 42000, 42500, 43000, 44000, 48000}
  };
  localparam int PIXEL_KHZ_DEF = 25000;

  // ==========================================================
  // APB register map
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam int          CTRL_VAR_LSB   = 0;
  localparam int          CTRL_FORCE_BIT = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam int          ST_PIX_LSB  = 0;
  localparam int          ST_MEM_LSB  = 4;
  localparam int          ST_PSET_BIT = 8;
  localparam int          ST_MSET_BIT = 9;
  localparam int          ST_PSYN_BIT = 10;
  localparam int          ST_MSYN_BIT = 11;
  localparam int          ST_OE_BIT   = 12;

  typedef enum logic {MUX_FOLLOW, MUX_HOLD} mux_state_t;

  // Half period in system cycles, never below one
  function automatic logic [HALF_W-1:0] half_cycles(input int khz);
    int h;
    h = (khz > 0) ? CLK_KHZ / (2 * khz) : 1;
    if (h < 1) h = 1;
    return HALF_W'(h);
  endfunction : half_cycles

endpackage : clk_sel_pkg

`default_nettype wire

// ==== hw/dual_clock_select_mux.sv ====
// Dual clock select top: pixel and memory clock selection, settling, output control.
// Assumes all pins synchronous to clk_i; the reference arrives as a sampled level.
`default_nettype none

module dual_clock_select_mux #(
  parameter int               SETTLE_REF_CYCLES = clk_sel_pkg::SETTLE_REF_CYCLES_DEF,
  parameter logic [16*32-1:0] PIXEL_TABLE_KHZ   =
    {16{32'(clk_sel_pkg::PIXEL_KHZ_DEF)}}
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        reference_clock_in_i,
  input  wire logic [3:0]  pixel_sel_i,
  input  wire logic [3:0]  pixel_sel_drv_i,
  input  wire logic [2:0]  memory_sel_i,
  input  wire logic [2:0]  memory_sel_drv_i,
  input  wire logic        output_disable_n_i,
  input  wire logic        output_disable_drv_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             pixel_clk_o,
  output logic             pixel_clk_oe_o,
  output logic             memory_clk_o,
  output logic             memory_clk_oe_o,
  output logic             buffered_ref_out_o,
  output logic             buffered_ref_oe_o,
  output logic             crystal_drive_out_o
);
  import clk_sel_pkg::*;

  // ==========================================================
  // Pad pulls: an undriven pin reads its pull level
  logic [3:0] pix_sel;
  logic [2:0] mem_sel;
  logic       out_en;
  assign pix_sel = (pixel_sel_i & pixel_sel_drv_i) | (PIXEL_SEL_PULL & ~pixel_sel_drv_i);
  assign mem_sel = (memory_sel_i & memory_sel_drv_i) | (MEMORY_SEL_PULL & ~memory_sel_drv_i);
  assign out_en  = output_disable_drv_i ? output_disable_n_i : OUT_DIS_PULL;

  // ==========================================================
  // Reference sampling, buffered copy and crystal drive
  logic ref_r;
  logic ref_rise;
  assign ref_rise = reference_clock_in_i & ~ref_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ref_r               <= 1'b0;
      buffered_ref_out_o  <= 1'b0;
      crystal_drive_out_o <= 1'b0;
    end else begin
      ref_r               <= reference_clock_in_i;
      buffered_ref_out_o  <= reference_clock_in_i;
      crystal_drive_out_o <= ~reference_clock_in_i;
    end
  end

  // ==========================================================
  // Output enables, all three together
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pixel_clk_oe_o    <= 1'b0;
      memory_clk_oe_o   <= 1'b0;
      buffered_ref_oe_o <= 1'b0;
    end else begin
      pixel_clk_oe_o    <= out_en;
      memory_clk_oe_o   <= out_en;
      buffered_ref_oe_o <= out_en;
    end
  end

  // ==========================================================
  // Control register
  logic [2:0] ctrl_r;
  logic [1:0] variant;
  logic       force_ref;
  assign variant   = ctrl_r[CTRL_VAR_LSB +: 2];
  assign force_ref = ctrl_r[CTRL_FORCE_BIT];

  // ==========================================================
  // Selection words and frequency lookup
  logic [3:0]        pix_sel_r;
  logic [4:0]        mem_word_r;
  logic [4:0]        mem_word;
  logic [HALF_W-1:0] pix_half_r;
  logic [HALF_W-1:0] mem_half_r;
  logic              pix_chg;
  logic              mem_chg;
  int                pix_khz;
  int                mem_khz;

  assign mem_word = {variant, mem_sel};
  assign pix_chg  = pix_sel != pix_sel_r;
  assign mem_chg  = mem_word != mem_word_r;
  // Unused variant code falls back to the first table
  assign mem_khz  = MEM_KHZ[(int'(variant) < MEM_VARIANTS) ? int'(variant) : 0][mem_sel];
  assign pix_khz  = int'(PIXEL_TABLE_KHZ[pix_sel*32 +: 32]);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pix_sel_r  <= PIXEL_SEL_PULL;
      mem_word_r <= {2'h0, MEMORY_SEL_PULL};
      pix_half_r <= half_cycles(int'(PIXEL_TABLE_KHZ[PIXEL_SEL_PULL*32 +: 32]));
      mem_half_r <= half_cycles(MEM_KHZ[0][MEMORY_SEL_PULL]);
    end else begin
      pix_sel_r  <= pix_sel;
      mem_word_r <= mem_word;
      if (pix_chg) pix_half_r <= half_cycles(pix_khz);
      if (mem_chg) mem_half_r <= half_cycles(mem_khz);
    end
  end

  // ==========================================================
  // Synthesized levels: square waves at the table half period
  logic [HALF_W-1:0] pix_hc_r;
  logic [HALF_W-1:0] mem_hc_r;
  logic              pix_syn_r;
  logic              mem_syn_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pix_hc_r  <= '0;
      mem_hc_r  <= '0;
      pix_syn_r <= 1'b0;
      mem_syn_r <= 1'b0;
    end else begin
      if (pix_hc_r >= pix_half_r - HALF_W'(1)) begin
        pix_hc_r  <= '0;
        pix_syn_r <= ~pix_syn_r;
      end else begin
        pix_hc_r <= pix_hc_r + HALF_W'(1);
      end
      if (mem_hc_r >= mem_half_r - HALF_W'(1)) begin
        mem_hc_r  <= '0;
        mem_syn_r <= ~mem_syn_r;
      end else begin
        mem_hc_r <= mem_hc_r + HALF_W'(1);
      end
    end
  end

  // ==========================================================
  // Settling counters in reference cycles; the count is coarse, not a lock detector
  logic [CNT_W-1:0] pix_cnt_r;
  logic [CNT_W-1:0] mem_cnt_r;
  logic             pix_settling_r;
  logic             mem_settling_r;
  logic             pix_done;
  logic             mem_done;
  assign pix_done = ref_rise && pix_cnt_r == CNT_W'(SETTLE_REF_CYCLES - 1);
  assign mem_done = ref_rise && mem_cnt_r == CNT_W'(SETTLE_REF_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pix_cnt_r      <= '0;
      mem_cnt_r      <= '0;
      pix_settling_r <= 1'b1;
      mem_settling_r <= 1'b1;
    end else begin
      if (pix_chg) begin
        pix_cnt_r      <= '0;
        pix_settling_r <= 1'b1;
      end else if (pix_settling_r && ref_rise) begin
        pix_cnt_r <= pix_cnt_r + CNT_W'(1);
        if (pix_done) pix_settling_r <= 1'b0;
      end
      if (mem_chg) begin
        mem_cnt_r      <= '0;
        mem_settling_r <= 1'b1;
      end else if (mem_settling_r && ref_rise) begin
        mem_cnt_r <= mem_cnt_r + CNT_W'(1);
        if (mem_done) mem_settling_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Output muxes
  logic pix_on_syn;
  logic mem_on_syn;

  glitch_free_mux u_pix_mux (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .ref_lvl_i (ref_r),
    .syn_lvl_i (pix_syn_r),
    .use_syn_i (~pix_settling_r & ~force_ref),
    .clk_o     (pixel_clk_o),
    .on_syn_o  (pix_on_syn)
  );

  glitch_free_mux u_mem_mux (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .ref_lvl_i (ref_r),
    .syn_lvl_i (mem_syn_r),
    .use_syn_i (~mem_settling_r & ~force_ref),
    .clk_o     (memory_clk_o),
    .on_syn_o  (mem_on_syn)
  );

  // ==========================================================
  // APB slave: two-cycle access phase, unmapped addresses answer with pslverr
  logic        acc;
  logic        mapped;
  logic [31:0] status;
  assign acc    = psel_i & penable_i;
  assign mapped = (paddr_i == CTRL_ADDR) || (paddr_i == STATUS_ADDR);

  always_comb begin
    status = '0;
    status[ST_PIX_LSB +: 4] = pix_sel_r;
    status[ST_MEM_LSB +: 3] = mem_word_r[2:0];
    status[ST_PSET_BIT]     = pix_settling_r;
    status[ST_MSET_BIT]     = mem_settling_r;
    status[ST_PSYN_BIT]     = pix_on_syn;
    status[ST_MSYN_BIT]     = mem_on_syn;
    status[ST_OE_BIT]       = pixel_clk_oe_o;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_r    <= CTRL_RESET;
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      if (acc && !pready_o) begin
        if (pwrite_i || !mapped) begin
          prdata_o <= '0;
        end else if (paddr_i == CTRL_ADDR) begin
          prdata_o <= {29'h0, ctrl_r};
        end else begin
          prdata_o <= status;
        end
      end
      if (acc && pready_o && pwrite_i && paddr_i == CTRL_ADDR) begin
        ctrl_r <= pwdata_i[2:0];
      end
    end
  end

  // ==========================================================
  oe_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i |=> pixel_clk_oe_o == $past(out_en) && memory_clk_oe_o == $past(out_en)
      && buffered_ref_oe_o == $past(out_en)) else $error("outputs ignore disable");
  disable_all_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (output_disable_drv_i && !output_disable_n_i) |=> !pixel_clk_oe_o && !memory_clk_oe_o
      && !buffered_ref_oe_o) else $error("an output stayed driven");
  pull_default_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (pixel_sel_drv_i == 4'h0 && memory_sel_drv_i == 3'h0) |-> pix_sel == PIXEL_SEL_PULL
      && mem_sel == MEMORY_SEL_PULL) else $error("undriven select level wrong");
  ref_buffer_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i |=> buffered_ref_out_o == $past(reference_clock_in_i))
    else $error("reference copy wrong");
  pix_retune_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && pix_chg |=> pix_settling_r && pix_cnt_r == '0
      && pix_half_r == half_cycles($past(pix_khz)))
    else $error("pixel change not taken");
  mem_retune_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && mem_chg |=> mem_settling_r && mem_cnt_r == '0
      && mem_half_r == half_cycles($past(mem_khz)))
    else $error("memory change not taken");
  settle_end_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (pix_done && !pix_chg) |=> !pix_settling_r) else $error("settling did not end");
  settle_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(mem_settling_r) |-> $past(mem_cnt_r) == CNT_W'(SETTLE_REF_CYCLES - 1))
    else $error("memory settled early");

endmodule : dual_clock_select_mux

`default_nettype wire

// ==== hw/glitch_free_mux.sv ====
// Glitch-free two-source clock mux (reference or synthesized level).
// Assumes both source levels are registered in the clk_i domain.
`default_nettype none

module glitch_free_mux (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ref_lvl_i,
  input  wire logic syn_lvl_i,
  input  wire logic use_syn_i,
  output var  logic clk_o,
  output var  logic on_syn_o
);
  import clk_sel_pkg::*;

  mux_state_t state_r;
  logic       cur_src;
  logic       new_src;

  assign cur_src = on_syn_o ? syn_lvl_i : ref_lvl_i;
  assign new_src = on_syn_o ? ref_lvl_i : syn_lvl_i;

  // ==========================================================
  // Switch only from a high level and rejoin on a low one, so no runt pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r  <= MUX_FOLLOW;
      clk_o    <= 1'b0;
      on_syn_o <= 1'b0;
    end else begin
      case (state_r)
        MUX_FOLLOW: begin
          if (use_syn_i != on_syn_o && cur_src) begin
            state_r <= MUX_HOLD;
            clk_o   <= 1'b1;
          end else begin
            clk_o <= cur_src;
          end
        end
        default: begin
          clk_o <= 1'b1;
          if (!new_src) begin
            on_syn_o <= ~on_syn_o;
            state_r  <= MUX_FOLLOW;
          end
        end
      endcase
    end
  end

  // ==========================================================
  hold_high_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_r == MUX_HOLD |=> clk_o) else $error("output not high while switching");
  source_swap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $changed(on_syn_o) |-> $past(state_r) == MUX_HOLD && !$past(new_src))
    else $error("source changed outside a hold");

endmodule : glitch_free_mux

`default_nettype wire

// ==== verif/dual_clock_select_mux_test.sv ====
// Self-checking bench of the dual clock select block against an integer model.
// Assumes the design package and the controller model are compiled before it.
`default_nettype none

module dual_clock_select_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_sel_pkg::*;
  // ==========================================================
  // Setup
  localparam int SETTLE = 8;
  function automatic logic [511:0] ptab();
    for (int i = 0; i < 16; i++) ptab[32*i +: 32] = 32'(5000 * (i + 1));
  endfunction : ptab
  localparam logic [511:0] PTAB = ptab();
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, pclk, poe, mclk, moe, bref, boe, xdrv, refc;
  logic [3:0]  pix_cmd = 4'h0, pix_drv = 4'hf, pix, pixd;
  logic [2:0]  mem_cmd = 3'h0, mem_drv = 3'h7, mem, memd;
  logic        dis_cmd = 1'b1, dis_drv = 1'b1, dis, disd, prev_ref = 1'b0;
  logic [7:0]  seed = 8'h19;
  int          mismatches = 0, n_checks = 0, n, m, v, pm, pv, sm;
  bit          live = 1'b0;

  initial begin
    forever #2.5 clk = ~clk;
  end

  gfx_ctrl_model i_gfx_ctrl_model (.clk_i(clk), .pix_cmd_i(pix_cmd), .pix_drv_i(pix_drv),
    .mem_cmd_i(mem_cmd), .mem_drv_i(mem_drv), .dis_cmd_i(dis_cmd), .dis_drv_i(dis_drv),
    .pix_o(pix), .pix_dv_o(pixd), .mem_o(mem), .mem_dv_o(memd), .dis_o(dis),
    .dis_dv_o(disd), .ref_o(refc));

  dual_clock_select_mux #(.SETTLE_REF_CYCLES(SETTLE), .PIXEL_TABLE_KHZ(PTAB))
  i_dual_clock_select_mux (.clk_i(clk), .resetn_i(resetn), .reference_clock_in_i(refc),
    .pixel_sel_i(pix), .pixel_sel_drv_i(pixd), .memory_sel_i(mem), .memory_sel_drv_i(memd),
    .output_disable_n_i(dis), .output_disable_drv_i(disd), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pixel_clk_o(pclk),
    .pixel_clk_oe_o(poe), .memory_clk_o(mclk), .memory_clk_oe_o(moe),
    .buffered_ref_out_o(bref), .buffered_ref_oe_o(boe), .crystal_drive_out_o(xdrv));

  // ==========================================================
  // Model and helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] st(int p, int mw, int sp, int sm, int oe);
    return 32'(p | mw << 4 | sp << 8 | sm << 9 | (1 - sp) << 10 | (1 - sm) << 11 | oe << 12);
  endfunction : st
  function automatic int half(int khz);
    return (200000 / (2 * khz) < 1) ? 1 : 200000 / (2 * khz);
  endfunction : half
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k >= 50) begin
      mismatches++;
      wrap_up();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // Length of one high phase, in system cycles
  task automatic hi_time(input bit mc, output int cnt);
    int k;
    cnt = 0;
    for (k = 0; k < 200 && (mc ? mclk : pclk) !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 200 && (mc ? mclk : pclk) !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 200 && (mc ? mclk : pclk) === 1'b1; k++) begin
      @(negedge clk);
      cnt++;
    end
  endtask : hi_time

  always @(negedge clk) begin
    if (live && boe === 1'b1) chk(32'(bref), 32'(prev_ref));
    if (live) chk(32'(xdrv), 32'(!prev_ref));
    prev_ref = refc;
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk(32'({poe, moe, boe}), 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    live = 1'b1;
    repeat (300) @(posedge clk);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, st(0, 0, 0, 0, 1));
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    {pm, pv} = 0;
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      m = int'(seed[2:0]);
      v = int'(seed[4:3]);
      sm = int'(m != pm || v != pv);
      @(posedge clk);
      pix_cmd <= 4'(k);
      mem_cmd <= 3'(m);
      apb(1'b1, CTRL_ADDR, 32'(v));
      apb(1'b0, STATUS_ADDR, 32'h0);
      // Mux source bits may still be moving here, so they are checked later
      chk(rd & 32'hffff_f3ff, st(k, m, int'(k != 0), sm, 1) & 32'hffff_f3ff);
      repeat (60) @(posedge clk);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, st(k, m, int'(k != 0), sm, 1));
      repeat (250) @(posedge clk);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, st(k, m, 0, 0, 1));
      hi_time(1'b0, n);
      chk(32'(n), 32'(half(5000 * (k + 1))));
      hi_time(1'b1, n);
      chk(32'(n), 32'(half(MEM_KHZ[(v == 3) ? 0 : v][m])));
      {pm, pv} = {m, v};
    end
    // Forced reference: both outputs leave the synthesizers and run at the reference rate
    apb(1'b1, CTRL_ADDR, 32'h4);
    repeat (60) @(posedge clk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(32'(rd[11:10]), 32'h0);
    hi_time(1'b0, n);
    chk(32'(n), 32'h7);
    hi_time(1'b1, n);
    chk(32'(n), 32'h7);
    apb(1'b1, CTRL_ADDR, 32'h0);
    @(posedge clk);
    {pix_drv, mem_drv} <= 7'h0;
    repeat (300) @(posedge clk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, st(7, 7, 0, 0, 1));
    dis_cmd <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'({poe, moe, boe}), 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, st(7, 7, 0, 0, 0));
    dis_drv <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'({poe, moe, boe}), 32'h7);
    wrap_up();
  end
endmodule : dual_clock_select_mux_test

`default_nettype wire

// ==== verif/gfx_ctrl_model.sv ====
// Far-side model: graphics controller select pins, disable pin and reference oscillator.
// Assumes bench commands change at rising clk_i edges; released pins toggle every cycle.
`default_nettype none

module gfx_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] pix_cmd_i,
  input  wire logic [3:0] pix_drv_i,
  input  wire logic [2:0] mem_cmd_i,
  input  wire logic [2:0] mem_drv_i,
  input  wire logic       dis_cmd_i,
  input  wire logic       dis_drv_i,
  output var  logic [3:0] pix_o,
  output var  logic [3:0] pix_dv_o,
  output var  logic [2:0] mem_o,
  output var  logic [2:0] mem_dv_o,
  output var  logic       dis_o,
  output var  logic       dis_dv_o,
  output var  logic       ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pins and reference
  int ref_cnt = 0;
  initial begin
    {pix_o, pix_dv_o, mem_o, mem_dv_o, dis_o, dis_dv_o, ref_o} = '0;
  end
  // Seven-cycle halves give about 14.29 MHz, near the nominal rate
  always @(posedge clk_i) begin
    ref_cnt <= (ref_cnt == 6) ? 0 : ref_cnt + 1;
    if (ref_cnt == 6) ref_o <= ~ref_o;
    // Released lines toggle, so a missing pad pull cannot hide
    pix_o <= (pix_cmd_i & pix_drv_i) | (~pix_drv_i & ~pix_o);
    mem_o <= (mem_cmd_i & mem_drv_i) | (~mem_drv_i & ~mem_o);
    dis_o <= (dis_cmd_i & dis_drv_i) | (~dis_drv_i & ~dis_o);
    {pix_dv_o, mem_dv_o, dis_dv_o} <= {pix_drv_i, mem_drv_i, dis_drv_i};
  end
endmodule : gfx_ctrl_model

`default_nettype wire
